// [src/cpmu_top.sv]
// core performance counter unit with off-chip reply filters
module cpmu_top
    import cpmu_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                reset_i,
    // model-specific register access
    input  wire cpmu_msr_req_t       msr_req_i,
    output logic                     msr_ack_o,
    output logic                     msr_err_o,
    output logic [63:0]              msr_rdata_o,
    // counter configuration
    input  wire logic [3:0]          gp_en_i,
    input  wire logic [3:0]          gp_all_cpus_i,
    input  wire logic [7:0]          gp_src_i,
    input  wire logic [3:0]          gp_load_i,
    input  wire logic [47:0]         load_val_i,
    input  wire logic [2:0]          fx_en_i,
    input  wire logic                frz_ctr_on_irq_i,
    input  wire logic                frz_brl_on_irq_i,
    input  wire logic                sample_en_i,
    // core events
    input  wire logic [3:0]          gp_event_i,
    input  wire logic [2:0]          fx_event_i,
    input  wire logic                req_start_i,
    input  wire logic [15:0]         req_start_type_i,
    input  wire logic                req_done_i,
    input  wire logic [15:0]         req_done_type_i,
    input  wire logic                sample_buf_ovf_i,
    input  wire logic                trace_buf_ovf_i,
    input  wire logic [63:0]         stamp_i,
    // global overflow status
    input  wire logic [63:0]         ovf_clear_i,
    input  wire logic [63:0]         ovf_force_i,
    output logic [63:0]              global_status_o,
    output logic [6:0]               counter_busy_o,
    output logic                     overflow_irq_o,
    output logic                     branch_log_frozen_o,
    // counts
    output logic [3:0][47:0]         gp_count_o,
    output logic [2:0][47:0]         fx_count_o,
    // sample request
    output logic                     sample_req_o,
    output logic [3:0]               sample_appl_o,
    output logic [63:0]              sample_stamp_o,
    output logic [3:0]               sample_fmt_o,
    output logic [7:0]               sample_stamp_ofs_o,
    // identification
    output logic [31:0]              id_eax_o,
    output logic [31:0]              id_edx_o
);

    //--------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------
    cpmu_filt_t         filt0_r;
    cpmu_filt_t         filt1_r;
    logic               ack_r;
    logic               err_r;
    logic [63:0]        rdata_r;
    logic               hit0;
    logic               hit1;
    logic [5:0]         pend_r;
    logic               st0;
    logic               dn0;
    logic               st1;
    logic [47:0]        f0_inc;
    logic [47:0]        f1_inc;
    logic [3:0][47:0]   gp_cnt_r;
    logic [3:0][47:0]   gp_inc;
    logic [3:0]         gp_run;
    logic [3:0]         gp_ovf;
    logic [2:0][47:0]   fx_cnt_r;
    logic [2:0]         fx_run;
    logic [2:0]         fx_ovf;
    logic [63:0]        gst_r;
    logic [63:0]        gst_set;
    logic               irq_evt;
    logic               counters_frozen_flag;
    logic               irq_r;
    logic               smp_r;
    logic [63:0]        smp_stamp_r;

    //--------------------------------------------------------------
    // register access
    //--------------------------------------------------------------
    assign hit0 = msr_req_i.addr == CPMU_ADR_FILT0;
    assign hit1 = msr_req_i.addr == CPMU_ADR_FILT1;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            filt0_r <= CPMU_FILT_RST;
            filt1_r <= CPMU_FILT_RST;
        end else if (msr_req_i.wr) begin
            if (hit0) begin
                filt0_r <= msr_req_i.wdata;
            end
            if (hit1) begin
                filt1_r <= msr_req_i.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
            rdata_r <= 64'h0;
        end else begin
            ack_r   <= msr_req_i.wr | msr_req_i.rd;
            err_r   <= (msr_req_i.wr | msr_req_i.rd) & ~(hit0 | hit1);
            if (msr_req_i.rd && hit0) begin
                rdata_r <= filt0_r;
            end else if (msr_req_i.rd && hit1) begin
                rdata_r <= filt1_r;
            end else begin
                rdata_r <= 64'h0;
            end
        end
    end

    assign msr_ack_o   = ack_r;
    assign msr_err_o   = err_r;
    assign msr_rdata_o = rdata_r;

    //--------------------------------------------------------------
    // reply filters
    //--------------------------------------------------------------
    assign st0 = req_start_i & |(req_start_type_i & filt0_r.req_type);
    assign dn0 = req_done_i & |(req_done_type_i & filt0_r.req_type);
    assign st1 = req_start_i & |(req_start_type_i & filt1_r.req_type);

    // outstanding requests of the filter zero type, saturating
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pend_r <= 6'h00;
        end else if (st0 && !dn0 && pend_r != 6'h3f) begin
            pend_r <= pend_r + 6'h01;
        end else if (dn0 && !st0 && pend_r != 6'h00) begin
            pend_r <= pend_r - 6'h01;
        end
    end

    always_comb begin
        if (filt0_r.pend_weight) begin
            f0_inc = {42'h0, pend_r};
        end else begin
            f0_inc = {47'h0, st0 & filt0_r.any_resp};
        end
    end

    assign f1_inc = {47'h0, st1 & filt1_r.any_resp};

    //--------------------------------------------------------------
    // general counters
    //--------------------------------------------------------------
    assign counters_frozen_flag = gst_r[CPMU_GST_COUNTERS_FROZEN_FLAG];

    for (genvar i = 0; i < CPMU_GP_NUM; i++) begin : g_gp
        logic [48:0] sum;

        // qualifier input has no effect on counting
        always_comb begin
            unique case (gp_src_i[2*i +: 2])
                CPMU_SRC_RAW: gp_inc[i] = {47'h0, gp_event_i[i]};
                CPMU_SRC_FILT0: gp_inc[i] = f0_inc;
                CPMU_SRC_FILT1: gp_inc[i] = f1_inc;
                default: gp_inc[i] = 48'h0;
            endcase
        end

        assign gp_run[i] = gp_en_i[i] & ~counters_frozen_flag;
        assign sum       = {1'b0, gp_cnt_r[i]} + {1'b0, gp_inc[i]};
        assign gp_ovf[i] = gp_run[i] & ~gp_load_i[i] & sum[48];

        always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
                gp_cnt_r[i] <= 48'h0;
            end else if (gp_load_i[i]) begin
                gp_cnt_r[i] <= load_val_i;
            end else if (gp_run[i]) begin
                gp_cnt_r[i] <= sum[47:0];
            end
        end
    end

    //--------------------------------------------------------------
    // fixed counters
    //--------------------------------------------------------------
    for (genvar j = 0; j < CPMU_FX_NUM; j++) begin : g_fx
        assign fx_run[j] = fx_en_i[j] & fx_event_i[j] & ~counters_frozen_flag;
        assign fx_ovf[j] = fx_run[j] & (&fx_cnt_r[j]);

        always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
                fx_cnt_r[j] <= 48'h0;
            end else if (fx_run[j]) begin
                fx_cnt_r[j] <= fx_cnt_r[j] + 48'h1;
            end
        end
    end

    assign gp_count_o     = gp_cnt_r;
    assign fx_count_o     = fx_cnt_r;
    assign counter_busy_o = {fx_en_i, gp_en_i};

    //--------------------------------------------------------------
    // global overflow status
    //--------------------------------------------------------------
    assign irq_evt = |{gp_ovf, fx_ovf};

    always_comb begin
        gst_set = 64'h0;
        gst_set[3:0] = gp_ovf;
        gst_set[CPMU_GST_FX_LSB +: 3] = fx_ovf;
        gst_set[CPMU_GST_TRACE] = trace_buf_ovf_i;
        gst_set[CPMU_GST_SMP_OVF] = sample_buf_ovf_i;
        gst_set[CPMU_GST_COUNTERS_FROZEN_FLAG] = irq_evt & frz_ctr_on_irq_i;
        gst_set[CPMU_GST_BRL_FRZ] = irq_evt & frz_brl_on_irq_i;
    end

    // set and force win over clear
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            gst_r <= CPMU_GST_RST;
        end else begin
            gst_r <= ((gst_r & ~ovf_clear_i) | gst_set | ovf_force_i)
                     & CPMU_GST_MASK;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_evt;
        end
    end

    assign global_status_o     = gst_r;
    assign overflow_irq_o      = irq_r;
    assign branch_log_frozen_o = gst_r[CPMU_GST_BRL_FRZ];

    //--------------------------------------------------------------
    // sample request, counter zero only
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            smp_r     <= 1'b0;
            smp_stamp_r <= 64'h0;
        end else begin
            smp_r <= sample_en_i & (gp_ovf[0] | ovf_force_i[0]);
            if (sample_en_i && (gp_ovf[0] || ovf_force_i[0])) begin
                smp_stamp_r <= stamp_i;
            end
        end
    end

    assign sample_req_o       = smp_r;
    assign sample_appl_o      = CPMU_SMP_APPL;
    assign sample_stamp_o     = smp_stamp_r;
    assign sample_fmt_o       = CPMU_REC_FMT;
    assign sample_stamp_ofs_o = CPMU_REC_STP_OFS;

    //--------------------------------------------------------------
    // identification
    //--------------------------------------------------------------
    always_comb begin
        id_eax_o = {8'h0, CPMU_CNT_WIDTH, CPMU_GP_COUNT,
                    CPMU_PM_VERSION};
        id_edx_o = {19'h0, CPMU_CNT_WIDTH, CPMU_FX_COUNT};
        id_edx_o[CPMU_EDX_ANY_DEPR] = 1'b0;
    end

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    AST_WEIGHT_ACC: assert property (
        gp_run[0] && !gp_load_i[0] && filt0_r.pend_weight
        && gp_src_i[1:0] == CPMU_SRC_FILT0
        |=> gp_cnt_r[0] == $past(gp_cnt_r[0]) + {42'h0, $past(pend_r)})
        else $error("weighted cycles not accumulated");

    AST_REQ_COUNT: assert property (
        gp_run[1] && !gp_load_i[1] && gp_src_i[3:2] == CPMU_SRC_FILT1
        |=> gp_cnt_r[1] == $past(gp_cnt_r[1])
            + {47'h0, $past(st1 & filt1_r.any_resp)})
        else $error("request count wrong");

    AST_PEND_UP: assert property (
        st0 && !dn0 && pend_r == 6'h02 |=> pend_r == 6'h03)
        else $error("pending count not raised");

    AST_ID: assert property (
        id_eax_o[7:0] == 8'h04 && id_eax_o[15:8] == 8'h04
        && id_edx_o[4:0] == 5'h03)
        else $error("identification counts wrong");

    AST_NO_DEPR: assert property (!id_edx_o[15])
        else $error("deprecation flag set");

    AST_FRZ_SET: assert property (
        irq_evt && frz_ctr_on_irq_i
        |=> counters_frozen_flag && overflow_irq_o)
        else $error("freeze flag not set");

    AST_FRZ_HOLD: assert property (
        counters_frozen_flag && !gp_load_i[0] |=> $stable(gp_cnt_r[0]))
        else $error("counter moved while frozen");

    AST_FORCE: assert property (
        ovf_force_i[0] |=> global_status_o[0])
        else $error("force did not set status");

    AST_CLEAR: assert property (
        ovf_clear_i[0] && !ovf_force_i[0] && !gp_ovf[0]
        |=> !global_status_o[0])
        else $error("clear did not reset status");

    AST_SMP_ZERO: assert property (
        sample_req_o |-> $past(gp_ovf[0] | ovf_force_i[0])
        && sample_appl_o == 4'h1)
        else $error("sample from wrong counter");

    AST_FMT: assert property (sample_fmt_o == 4'h3)
        else $error("record format wrong");

    AST_MSR_WR: assert property (
        msr_req_i.wr && hit1
        |=> filt1_r == $past(msr_req_i.wdata) && msr_ack_o && !msr_err_o)
        else $error("filter one write lost");

    CV_WEIGHT: cover property (
        filt0_r.pend_weight && pend_r > 6'h01 && gp_run[0]);
    CV_FREEZE: cover property (irq_evt && frz_ctr_on_irq_i ##1 counters_frozen_flag);
    CV_SAMPLE: cover property (sample_req_o);
    CV_MSR_ERR: cover property (msr_err_o);
endmodule

// [common/cpmu_pkg.sv]
// constants and types of the core performance counter unit
package cpmu_pkg;
    localparam int unsigned CPMU_GP_NUM       = 4;
    localparam int unsigned CPMU_FX_NUM       = 3;
    localparam int unsigned CPMU_CW           = 48;
    localparam int unsigned CPMU_PW           = 6;
    localparam logic [15:0] CPMU_ADR_FILT0    = 16'h01a6;
    localparam logic [15:0] CPMU_ADR_FILT1    = 16'h01a7;
    localparam logic [63:0] CPMU_FILT_RST     = 64'h0;
    localparam logic [7:0]  CPMU_PM_VERSION   = 8'h04;
    localparam logic [7:0]  CPMU_GP_COUNT     = 8'h04;
    localparam logic [4:0]  CPMU_FX_COUNT     = 5'h03;
    localparam logic [7:0]  CPMU_CNT_WIDTH    = 8'h30;
    localparam int unsigned CPMU_EDX_ANY_DEPR = 15;
    localparam logic [3:0]  CPMU_REC_FMT      = 4'h3;
    localparam logic [7:0]  CPMU_REC_APPL_OFS = 8'h90;
    localparam logic [7:0]  CPMU_REC_DLA_OFS  = 8'h98;
    localparam logic [7:0]  CPMU_REC_STP_OFS  = 8'hc0;
    localparam logic [3:0]  CPMU_SMP_APPL     = 4'h1;
    localparam int unsigned CPMU_GST_FX_LSB   = 32;
    localparam int unsigned CPMU_GST_TRACE    = 55;
    localparam int unsigned CPMU_GST_BRL_FRZ  = 58;
    localparam int unsigned CPMU_GST_COUNTERS_FROZEN_FLAG  = 59;
    localparam int unsigned CPMU_GST_SMP_OVF  = 62;
    localparam logic [63:0] CPMU_GST_MASK     = 64'h4c80_0007_0000_000f;
    localparam logic [63:0] CPMU_GST_RST      = 64'h0;
    localparam logic [1:0]  CPMU_SRC_RAW      = 2'h0;
    localparam logic [1:0]  CPMU_SRC_FILT0    = 2'h1;
    localparam logic [1:0]  CPMU_SRC_FILT1    = 2'h2;

    typedef struct packed {
        logic [24:0] rsvd_hi;
        logic        pend_weight;
        logic [20:0] resp_detail;
        logic        any_resp;
        logic [15:0] req_type;
    } cpmu_filt_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [63:0] wdata;
    } cpmu_msr_req_t;
endpackage

// [verification/cpmu_top_tb_top.sv]
// self-checking bench for the core performance counter unit
module cpmu_top_tb_top
    import cpmu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    logic             sys_clk_i, reset_i, msr_ack_o, msr_err_o;
    logic             frz_ctr_on_irq_i, frz_brl_on_irq_i, sample_en_i;
    logic             req_start_i, req_done_i, overflow_irq_o;
    logic             sample_buf_ovf_i, trace_buf_ovf_i;
    logic             branch_log_frozen_o, sample_req_o;
    cpmu_msr_req_t    msr_req_i;
    logic [63:0]      msr_rdata_o, stamp_i, ovf_clear_i, ovf_force_i;
    logic [63:0]      global_status_o, sample_stamp_o;
    logic [3:0]       gp_en_i, gp_all_cpus_i, gp_load_i, gp_event_i;
    logic [3:0]       sample_appl_o, sample_fmt_o;
    logic [7:0]       gp_src_i, sample_stamp_ofs_o;
    logic [47:0]      load_val_i, hold_v, hold_f;
    logic [2:0]       fx_en_i, fx_event_i;
    logic [15:0]      req_start_type_i, req_done_type_i;
    logic [6:0]       counter_busy_o;
    logic [3:0][47:0] gp_count_o;
    logic [2:0][47:0] fx_count_o;
    logic [31:0]      id_eax_o, id_edx_o;
    logic [63:0]      filt_m [2];
    int               bad_count, n_checks, seed, pend_m, w0_m, c1_m;

    cpmu_top cpmu_top_inst (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .msr_req_i(msr_req_i),
        .msr_ack_o(msr_ack_o), .msr_err_o(msr_err_o),
        .msr_rdata_o(msr_rdata_o), .gp_en_i(gp_en_i),
        .gp_all_cpus_i(gp_all_cpus_i), .gp_src_i(gp_src_i),
        .gp_load_i(gp_load_i), .load_val_i(load_val_i), .fx_en_i(fx_en_i),
        .frz_ctr_on_irq_i(frz_ctr_on_irq_i),
        .frz_brl_on_irq_i(frz_brl_on_irq_i), .sample_en_i(sample_en_i),
        .gp_event_i(gp_event_i), .fx_event_i(fx_event_i),
        .req_start_i(req_start_i), .req_start_type_i(req_start_type_i),
        .req_done_i(req_done_i), .req_done_type_i(req_done_type_i),
        .sample_buf_ovf_i(sample_buf_ovf_i),
        .trace_buf_ovf_i(trace_buf_ovf_i), .stamp_i(stamp_i),
        .ovf_clear_i(ovf_clear_i), .ovf_force_i(ovf_force_i),
        .global_status_o(global_status_o), .counter_busy_o(counter_busy_o),
        .overflow_irq_o(overflow_irq_o),
        .branch_log_frozen_o(branch_log_frozen_o),
        .gp_count_o(gp_count_o), .fx_count_o(fx_count_o),
        .sample_req_o(sample_req_o), .sample_appl_o(sample_appl_o),
        .sample_stamp_o(sample_stamp_o), .sample_fmt_o(sample_fmt_o),
        .sample_stamp_ofs_o(sample_stamp_ofs_o), .id_eax_o(id_eax_o),
        .id_edx_o(id_edx_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n = 1);
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one register access, answer checked against the model
    task automatic msr(input logic [15:0] a, input logic w,
                       input logic [63:0] d);
        logic hit;
        hit = (a == CPMU_ADR_FILT0) || (a == CPMU_ADR_FILT1);
        msr_req_i = '{addr: a, wr: w, rd: !w, wdata: d};
        cyc();
        msr_req_i = '0;
        chk(msr_ack_o, 64'h1, "ack");
        chk(msr_err_o, !hit, "err");
        if (!w) begin
            chk(msr_rdata_o, hit ? filt_m[a[0]] : 64'h0, "rdata");
        end else if (hit) begin
            filt_m[a[0]] = d;
        end
        cyc();
        chk(msr_ack_o, 64'h0, "ack pulse");
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        $display("wrong value at %0t: run did not finish", $time);
        give_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 50;
        bad_count = 0;
        n_checks = 0;
        filt_m = '{default: 64'h0};
        reset_i = 1'b1;
        msr_req_i = '0;
        gp_en_i = 4'h0;
        gp_all_cpus_i = 4'h0;
        gp_src_i = 8'hff;
        gp_load_i = 4'h0;
        load_val_i = 48'h0;
        fx_en_i = 3'h0;
        fx_event_i = 3'h0;
        gp_event_i = 4'h0;
        frz_ctr_on_irq_i = 1'b0;
        frz_brl_on_irq_i = 1'b0;
        sample_en_i = 1'b0;
        req_start_i = 1'b0;
        req_done_i = 1'b0;
        req_start_type_i = 16'h0;
        req_done_type_i = 16'h0001;
        sample_buf_ovf_i = 1'b0;
        trace_buf_ovf_i = 1'b0;
        stamp_i = 64'h0123_4567_89ab_cdef;
        ovf_clear_i = 64'h0;
        ovf_force_i = 64'h0;
        cyc(3);
        reset_i = 1'b0;
        // identification and constants
        chk(global_status_o, 64'h0, "status reset");
        chk(id_eax_o[7:0], 64'h4, "version");
        chk(id_eax_o[15:8], 64'h4, "general counters");
        chk(id_edx_o[4:0], 64'h3, "fixed counters");
        chk(id_edx_o[15], 64'h0, "deprecation flag");
        chk(sample_fmt_o, 64'h3, "record format");
        chk(sample_stamp_ofs_o, 64'hc0, "timestamp offset");
        chk(sample_appl_o, 64'h1, "counter zero only");
        end_test("identification");
        // filter registers, reset values, unmapped neighbours
        msr(CPMU_ADR_FILT0, 1'b0, 64'h0);
        msr(CPMU_ADR_FILT1, 1'b0, 64'h0);
        for (int i = 0; i < 8; i++) begin
            msr(16'h01a5 + 16'(i % 4), i < 4, {$random(seed), $random(seed)});
        end
        end_test("registers");
        // weighted cycles on counter 0, request count on counter 1
        msr(CPMU_ADR_FILT0, 1'b1, 64'h0000_0040_0000_0001);
        msr(CPMU_ADR_FILT1, 1'b1, 64'h0000_0000_0001_0001);
        gp_src_i = 8'hf9;
        gp_en_i = 4'h3;
        w0_m = 0;
        c1_m = 0;
        pend_m = 0;
        for (int i = 0; i < 60; i++) begin
            req_start_i = 1'($random(seed));
            req_start_type_i = 1'($random(seed)) ? 16'h0001 : 16'h0002;
            req_done_i = 1'($random(seed)) && pend_m > 0;
            gp_all_cpus_i = 4'($random(seed));
            w0_m += pend_m;
            if (req_start_i && req_start_type_i == 16'h0001) begin
                c1_m++;
                pend_m++;
            end
            if (req_done_i) begin
                pend_m--;
            end
            cyc();
            chk(gp_count_o[0], 64'(w0_m), "weighted cycles");
            chk(gp_count_o[1], 64'(c1_m), "request count");
        end
        req_start_i = 1'b0;
        req_done_i = 1'b0;
        if (c1_m > 0) begin
            hold_v = gp_count_o[0] / gp_count_o[1];
            chk(hold_v, 48'(w0_m / c1_m), "average latency");
        end
        end_test("latency");
        // overflow of counter 0 with freeze and sampling
        gp_src_i = 8'hfc;
        gp_en_i = 4'h1;
        fx_en_i = 3'h1;
        fx_event_i = 3'h1;
        frz_ctr_on_irq_i = 1'b1;
        frz_brl_on_irq_i = 1'b1;
        sample_en_i = 1'b1;
        gp_load_i = 4'h1;
        load_val_i = 48'hffff_ffff_fffe;
        cyc();
        gp_load_i = 4'h0;
        chk(counter_busy_o, 64'h11, "in use");
        gp_event_i = 4'h1;
        cyc(2);
        chk(global_status_o[0], 64'h1, "overflow bit");
        chk(gp_count_o[0], 64'h0, "wrapped count");
        chk(overflow_irq_o, 64'h1, "interrupt");
        chk(global_status_o[59:58], 64'h3, "frozen flags");
        chk(branch_log_frozen_o, 64'h1, "branch log frozen");
        chk(sample_req_o, 64'h1, "sample request");
        chk(sample_stamp_o, stamp_i, "sample timestamp");
        hold_v = gp_count_o[0];
        hold_f = fx_count_o[0];
        cyc(4);
        chk(gp_count_o[0], hold_v, "frozen general");
        chk(fx_count_o[0], hold_f, "frozen fixed");
        chk(overflow_irq_o, 64'h0, "interrupt pulse");
        chk(sample_req_o, 64'h0, "sample pulse");
        ovf_clear_i = 64'h0c00_0000_0000_0001;
        cyc();
        ovf_clear_i = 64'h0;
        chk(global_status_o, 64'h0, "cleared");
        cyc();
        chk(gp_count_o[0], hold_v + 48'h1, "resumed");
        end_test("freeze");
        // force, force beating clear, buffer overflow inputs
        gp_en_i = 4'h0;
        fx_en_i = 3'h0;
        gp_event_i = 4'h0;
        frz_ctr_on_irq_i = 1'b0;
        frz_brl_on_irq_i = 1'b0;
        sample_en_i = 1'b0;
        ovf_force_i = 64'h4080_0004_0000_0002;
        cyc();
        ovf_force_i = 64'h8;
        ovf_clear_i = '1;
        chk(global_status_o, 64'h4080_0004_0000_0002, "forced");
        cyc();
        ovf_force_i = 64'h0;
        ovf_clear_i = 64'h0;
        sample_buf_ovf_i = 1'b1;
        trace_buf_ovf_i = 1'b1;
        chk(global_status_o, 64'h8, "force beats clear");
        cyc();
        sample_buf_ovf_i = 1'b0;
        trace_buf_ovf_i = 1'b0;
        chk(global_status_o, 64'h4080_0000_0000_0008, "buffer flags");
        end_test("status");
        give_verdict();
    end
endmodule
